// File: rtl/acc_map.svh
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// start source select codes
`define ACC_SRC_SW 3'h0
`define ACC_SRC_TMR3 3'h1
`define ACC_SRC_EXT 3'h2
`define ACC_SRC_TMR2 3'h3
`define ACC_SRC_SHARED 3'h4

// timing
`define ACC_CLK_FREQ_KHZ 10000
`define ACC_MAX_RATE_KSPS 500
`define ACC_MIN_START_CYC ((`ACC_CLK_FREQ_KHZ + `ACC_MAX_RATE_KSPS - 1) / `ACC_MAX_RATE_KSPS)
`define ACC_MAX_SAR_KHZ 7500
`define ACC_DIV_MAX 31
`define ACC_LP_TRACK_CLKS 3
`define ACC_CONV_CLKS 8

// widths and reset values
`define ACC_DATA_W 8
`define ACC_RST_DATA 8'h00
`define ACC_RST_GUARD 8'h00
`define ACC_RST_DIV_CNT 5'h00
`define ACC_RST_PH_CNT 4'h0

`endif

// File: rtl/acc_pkg.sv
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_TRACK,
        ACC_CONV
    } acc_state_t;

    typedef struct packed {
        acc_state_t st;
        logic [4:0] div_cnt;
        logic tick;
        logic [3:0] ph_cnt;
        logic [7:0] guard;
        logic busy;
        logic done;
        logic [7:0] data;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] lvl;
        logic sh_start;
    } acc_regs_t;

endpackage : acc_pkg

// File: rtl/acc_conv2_ctrl.sv
`timescale 1ns/1ps
`include "acc_map.svh"

// Overview of operation
// - conversion clock is system clock over divider+1
// - starts accepted at most 500 ksps
// - three-bit select picks one of five sources
// - software busy write starts a conversion
// - timer 3 or timer 2 overflow starts conversion
// - rising edge on external start pin starts
// - first converter busy write starts both converters
// - own pin if enabled, else shared pin
// - busy high during conversion, low after
// - busy falling edge sets done, requests interrupt
// - result stored in data word on completion
// - normal mode tracks except while converting
// - low-power mode tracks three conversion clocks first
// - low-power external start tracks while pin low
// - tracking shut down in chip sleep
// - each pair bit makes adjacent inputs differential
// - select code picks input and pair polarity
module acc_conv2_ctrl
    import acc_pkg::*;
#(
    parameter int CONV_CLKS = `ACC_CONV_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] conv_clk_divider,
    input wire logic [2:0] start_source_select,
    input wire logic low_power_track_bit,
    input wire logic conv2_busy_wr,
    input wire logic conv0_busy_wr,
    input wire logic timer3_ovf,
    input wire logic timer2_ovf,
    input wire logic ext_start_own_pin,
    input wire logic ext_start_shared_pin,
    input wire logic xbar_own_en,
    input wire logic xbar_shared_en,
    input wire logic chip_sleep,
    input wire logic done_clear,
    input wire logic done_int_en,
    input wire logic [3:0] pair_config_bits,
    input wire logic [2:0] input_select_code,
    input wire logic [7:0] sar_result,
    output logic conv2_busy_bit,
    output logic conv2_done_flag,
    output logic conv2_irq,
    output logic [7:0] conv2_data,
    output logic conv_clk_tick,
    output logic track_en,
    output logic [2:0] mux_pos_sel,
    output logic [2:0] mux_neg_sel,
    output logic mux_diff,
    output logic conv0_sync_start
);

    ////////////////////////////////////////////////////////////////////////////

    acc_regs_t r_q;
    acc_regs_t r_d;
    logic [1:0] rise;
    logic ext_rise;
    logic ext_lvl;
    logic start_req;
    logic accept;
    logic finish;
    logic pair_sel;

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        r_d = r_q;
        // pins pass three flops; a level counts once stages two and three agree
        r_d.s1 = {ext_start_shared_pin, ext_start_own_pin};
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < 2; i++) begin
            if (r_q.s2[i] == r_q.s3[i]) begin
                r_d.lvl[i] = r_q.s3[i];
            end
        end
        rise = r_d.lvl & ~r_q.lvl;
        // own pin wins; the shared pin serves only when the own pin is off
        ext_rise = xbar_own_en ? rise[0] : (xbar_shared_en & rise[1]);
        ext_lvl = xbar_own_en ? r_q.lvl[0] : (xbar_shared_en & r_q.lvl[1]);
        r_d.sh_start = ~xbar_own_en & xbar_shared_en & rise[1];

        // divider: counter compares with >= so a shrinking divisor cannot wrap
        r_d.tick = (r_q.div_cnt >= conv_clk_divider);
        r_d.div_cnt = r_d.tick ? `ACC_RST_DIV_CNT : r_q.div_cnt + 5'h01;

        unique case (start_source_select)
            `ACC_SRC_SW: start_req = conv2_busy_wr;
            `ACC_SRC_TMR3: start_req = timer3_ovf;
            `ACC_SRC_EXT: start_req = ext_rise;
            `ACC_SRC_TMR2: start_req = timer2_ovf;
            `ACC_SRC_SHARED: start_req = conv0_busy_wr;
            default: start_req = 1'b0;
        endcase

        // a start during a conversion or inside the rate window is dropped
        accept = start_req & ~r_q.busy & (r_q.guard == `ACC_RST_GUARD);
        finish = 1'b0;
        if (r_q.guard != `ACC_RST_GUARD) begin
            r_d.guard = r_q.guard - 8'h01;
        end

        unique case (r_q.st)
            ACC_IDLE: begin
                if (accept) begin
                    r_d.busy = 1'b1;
                    r_d.ph_cnt = `ACC_RST_PH_CNT;
                    r_d.guard = 8'(`ACC_MIN_START_CYC - 1);
                    // pin start in low-power mode tracked while low already
                    if (low_power_track_bit && start_source_select != `ACC_SRC_EXT) begin
                        r_d.st = ACC_TRACK;
                    end else begin
                        r_d.st = ACC_CONV;
                    end
                end
            end
            ACC_TRACK: begin
                if (r_q.tick) begin
                    r_d.ph_cnt = r_q.ph_cnt + 4'h1;
                    if (r_q.ph_cnt == 4'(`ACC_LP_TRACK_CLKS - 1)) begin
                        r_d.st = ACC_CONV;
                        r_d.ph_cnt = `ACC_RST_PH_CNT;
                    end
                end
            end
            ACC_CONV: begin
                if (r_q.tick) begin
                    r_d.ph_cnt = r_q.ph_cnt + 4'h1;
                    if (r_q.ph_cnt == 4'(CONV_CLKS - 1)) begin
                        finish = 1'b1;
                    end
                end
            end
        endcase

        if (finish) begin
            r_d.st = ACC_IDLE;
            r_d.busy = 1'b0;
            r_d.data = sar_result;
        end

        // hardware set wins over a software clear in the same cycle
        if (done_clear) begin
            r_d.done = 1'b0;
        end
        if (finish) begin
            r_d.done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign conv2_busy_bit = r_q.busy;
    assign conv2_done_flag = r_q.done;
    assign conv2_irq = r_q.done & done_int_en;
    assign conv2_data = r_q.data;
    assign conv_clk_tick = r_q.tick;
    assign conv0_sync_start = r_q.sh_start;

    // idle tracking: continuous in normal mode; in low-power mode only in pin mode while the pin is low
    always_comb begin
        unique case (r_q.st)
            ACC_IDLE: begin
                if (!low_power_track_bit) begin
                    track_en = 1'b1;
                end else begin
                    track_en = (start_source_select == `ACC_SRC_EXT) & ~ext_lvl;
                end
            end
            ACC_TRACK: track_en = 1'b1;
            ACC_CONV: track_en = 1'b0;
            default: track_en = 1'b0;
        endcase
        if (chip_sleep) begin
            track_en = 1'b0;
        end
    end

    // paired inputs: even code puts the even pin positive, odd code reverses
    assign pair_sel = pair_config_bits[input_select_code[2:1]];
    assign mux_pos_sel = input_select_code;
    assign mux_neg_sel = pair_sel ? (input_select_code ^ 3'h1) : 3'h0;
    assign mux_diff = pair_sel;

    ////////////////////////////////////////////////////////////////////////////
    // helper logic for the checks below

    logic [5:0] gap_q;
    logic div_chg_q;
    logic [7:0] since_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 6'h00;
            div_chg_q <= 1'b1;
            since_q <= 8'hff;
        end else begin
            gap_q <= r_q.tick ? 6'h01 : gap_q + 6'h01;
            div_chg_q <= r_q.tick ? 1'b0 : (div_chg_q | (conv_clk_divider != $past(conv_clk_divider)));
            since_q <= accept ? 8'h01 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    sequence s_conv_start;
        accept ##1 conv2_busy_bit;
    endsequence

    sequence s_lp_track;
        (r_q.st == ACC_TRACK) && conv2_busy_bit;
    endsequence

    property p_div_period;
        @(posedge clk) disable iff (!rst_n)
        conv_clk_tick && !div_chg_q && !(conv_clk_divider != $past(conv_clk_divider))
            |-> gap_q == {1'b0, conv_clk_divider} + 6'h01;
    endproperty
    a_div_period: assert property (p_div_period) else $error("conversion clock period wrong");

    property p_rate;
        @(posedge clk) disable iff (!rst_n)
        accept |-> since_q >= 8'h14;
    endproperty
    a_rate: assert property (p_rate) else $error("start accepted too soon");

    property p_illegal_src;
        @(posedge clk) disable iff (!rst_n)
        start_source_select > `ACC_SRC_SHARED |-> !accept;
    endproperty
    a_illegal_src: assert property (p_illegal_src) else $error("start from unused source code");

    property p_sw_start;
        @(posedge clk) disable iff (!rst_n)
        start_source_select == `ACC_SRC_SW && conv2_busy_wr && !conv2_busy_bit && r_q.guard == 8'h00
            |-> s_conv_start;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start missed");

    property p_tmr_start;
        @(posedge clk) disable iff (!rst_n)
        ((start_source_select == `ACC_SRC_TMR3 && timer3_ovf) || (start_source_select == `ACC_SRC_TMR2 && timer2_ovf))
            && !conv2_busy_bit && r_q.guard == 8'h00 |=> conv2_busy_bit;
    endproperty
    a_tmr_start: assert property (p_tmr_start) else $error("timer start missed");

    property p_shared_start;
        @(posedge clk) disable iff (!rst_n)
        start_source_select == `ACC_SRC_SHARED && conv0_busy_wr && !conv2_busy_bit && r_q.guard == 8'h00
            |=> conv2_busy_bit;
    endproperty
    a_shared_start: assert property (p_shared_start) else $error("shared start missed");

    property p_ext_start;
        @(posedge clk) disable iff (!rst_n)
        start_source_select == `ACC_SRC_EXT && xbar_own_en && r_q.s2[0] && r_q.s3[0] && !r_q.lvl[0]
            && !conv2_busy_bit && r_q.guard == 8'h00 |=> conv2_busy_bit;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("pin start missed");

    property p_busy_hold;
        @(posedge clk) disable iff (!rst_n)
        $rose(conv2_busy_bit) |-> conv2_busy_bit [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_done;
        @(posedge clk) disable iff (!rst_n)
        $fell(conv2_busy_bit) |-> conv2_done_flag && (conv2_irq == done_int_en);
    endproperty
    a_done: assert property (p_done) else $error("done flag not set at end");

    property p_data;
        @(posedge clk) disable iff (!rst_n)
        $fell(conv2_busy_bit) |-> conv2_data == $past(sar_result);
    endproperty
    a_data: assert property (p_data) else $error("result not stored");

    property p_lp_track;
        @(posedge clk) disable iff (!rst_n)
        accept && low_power_track_bit && start_source_select != `ACC_SRC_EXT && !chip_sleep
            |=> s_lp_track;
    endproperty
    a_lp_track: assert property (p_lp_track) else $error("low-power track phase missing");

    property p_conv_no_track;
        @(posedge clk) disable iff (!rst_n)
        r_q.st == ACC_CONV |-> !track_en;
    endproperty
    a_conv_no_track: assert property (p_conv_no_track) else $error("tracking during conversion");

    property p_sleep;
        @(posedge clk) disable iff (!rst_n)
        chip_sleep |-> !track_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("tracking while asleep");

    property p_mux;
        @(posedge clk) disable iff (!rst_n)
        mux_diff |-> (mux_neg_sel[2:1] == mux_pos_sel[2:1]) && (mux_neg_sel[0] != mux_pos_sel[0]);
    endproperty
    a_mux: assert property (p_mux) else $error("pair polarity wrong");

    property p_no_restart;
        @(posedge clk) disable iff (!rst_n)
        conv2_busy_bit && r_q.st == ACC_CONV |=> r_q.st != ACC_TRACK;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

    property p_track_phase;
        @(posedge clk) disable iff (!rst_n)
        r_q.st == ACC_TRACK && !chip_sleep |-> track_en;
    endproperty
    a_track_phase: assert property (p_track_phase) else $error("no tracking in track phase");

    property p_lp_pin_high;
        @(posedge clk) disable iff (!rst_n)
        low_power_track_bit && start_source_select == `ACC_SRC_EXT && r_q.st == ACC_IDLE && ext_lvl |-> !track_en;
    endproperty
    a_lp_pin_high: assert property (p_lp_pin_high) else $error("tracking while start pin high");

    property p_sync_pin;
        @(posedge clk) disable iff (!rst_n)
        conv0_sync_start |-> $past(!xbar_own_en && xbar_shared_en);
    endproperty
    a_sync_pin: assert property (p_sync_pin) else $error("shared start pulse without shared pin");

endmodule : acc_conv2_ctrl

// File: testbench/acc_far_side.sv
`timescale 1ns/1ps

// timers, converter core and result source outside the control block
module acc_far_side (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic busy,
    input wire logic fire3,
    input wire logic fire2,
    input wire logic [7:0] held,
    output logic timer3_ovf,
    output logic timer2_ovf,
    output logic [7:0] sar_result
);
    // result stands only while converting; otherwise it toggles so a mistimed sample shows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer3_ovf <= 1'b0;
            timer2_ovf <= 1'b0;
            sar_result <= 8'h00;
        end else begin
            timer3_ovf <= fire3;
            timer2_ovf <= fire2;
            sar_result <= busy ? held : ~sar_result;
        end
    end
endmodule : acc_far_side

// File: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic clk = 0;
    logic rst_n = 0;
    logic [4:0] div = 5'h01;
    logic [2:0] sel = 0;
    logic lp = 0, wr2 = 0, wr0 = 0, f3 = 0, f2 = 0, pin_o = 0, pin_s = 0;
    logic en_o = 1, en_s = 0, slp = 0, dclr = 0, ien = 1;
    logic [3:0] pairs = 0;
    logic [2:0] code = 0;
    logic [7:0] held = 0;
    logic t3, t2, busy, done, irq, tick, trk, diff, sync;
    logic [7:0] sar, data;
    logic [2:0] pos, neg;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 32'haa429a3a;
    int n;
    logic sync_seen;

    always #50 clk = ~clk;

    acc_conv2_ctrl i_acc_conv2_ctrl (.clk(clk), .rst_n(rst_n), .conv_clk_divider(div),
        .start_source_select(sel), .low_power_track_bit(lp), .conv2_busy_wr(wr2), .conv0_busy_wr(wr0),
        .timer3_ovf(t3), .timer2_ovf(t2), .ext_start_own_pin(pin_o), .ext_start_shared_pin(pin_s),
        .xbar_own_en(en_o), .xbar_shared_en(en_s), .chip_sleep(slp), .done_clear(dclr),
        .done_int_en(ien), .pair_config_bits(pairs), .input_select_code(code), .sar_result(sar),
        .conv2_busy_bit(busy), .conv2_done_flag(done), .conv2_irq(irq), .conv2_data(data),
        .conv_clk_tick(tick), .track_en(trk), .mux_pos_sel(pos), .mux_neg_sel(neg),
        .mux_diff(diff), .conv0_sync_start(sync));

    acc_far_side i_acc_far_side (.clk(clk), .rst_n(rst_n), .busy(busy), .fire3(f3), .fire2(f2),
        .held(held), .timer3_ovf(t3), .timer2_ovf(t2), .sar_result(sar));

    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // source events: 0 sw, 1 timer3, 2 own pin, 3 timer2, 4 shared write, 5 shared pin
    task fire(input int s);
        @(negedge clk);
        case (s)
            0: wr2 = 1;
            1: f3 = 1;
            2: pin_o = 1;
            3: f2 = 1;
            4: wr0 = 1;
            default: pin_s = 1;
        endcase
        @(negedge clk);
        {wr2, f3, f2, wr0} = '0;
    endtask : fire

    task run(input int s, input int ticks, input logic go);
        int t;
        int k;
        held = 8'($random(seed));
        sync_seen = 0;
        fire(s);
        for (k = 0; k < 12; k++) begin
            sync_seen |= sync;
            if (busy === 1'b1) break;
            @(negedge clk);
        end
        chk(busy, go, "busy start");
        chk(sync_seen, 8'(s == 5 && !en_o), "sync start");
        t = 0;
        for (k = 0; k < 1000 && busy === 1'b1; k++) begin
            if (tick === 1'b1) t++;
            if (!lp) chk(trk, 0, "track busy");
            // late enough that the rate window is over, so only busy can block it
            wr2 = (k == 21);
            @(negedge clk);
        end
        wr2 = 0;
        if (go) begin
            chk(8'(t), 8'(ticks), "ticks");
            chk(done, 1, "done");
            chk(data, held, "data");
            chk(irq, ien, "irq");
        end
        if (lp && s == 2) chk(trk, 0, "lp pin high track");
        @(negedge clk);
        {pin_o, pin_s, dclr} = 3'b001;
        @(negedge clk);
        dclr = 0;
        chk(done, 0, "done clear");
    endtask : run

    task gap;
        int k;
        int c;
        for (k = 0; k < 40 && tick !== 1'b1; k++) @(negedge clk);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (tick !== 1'b1 && c < 40);
        chk(8'(c), 8'(div) + 8'h01, "tick gap");
    endtask : gap

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        chk(trk, 1, "idle track");
        slp = 1;
        #1 chk(trk, 0, "sleep track");
        @(negedge clk);
        slp = 0;
        for (n = 0; n < 128; n++) begin
            @(negedge clk);
            {pairs, code} = n[6:0];
            #1;
            chk(pos, code, "pos");
            chk(neg, pairs[code[2:1]] ? (code[0] ? code - 3'h1 : code + 3'h1) : 3'h0, "neg");
            chk(diff, pairs[code[2:1]], "diff");
        end
        for (n = 0; n < 5; n++) begin
            sel = n[2:0];
            run(n, 8, 1);
            repeat (25) @(negedge clk);
        end
        sel = 3'h1;
        run(3, 8, 0);
        for (n = 5; n < 8; n++) begin
            sel = n[2:0];
            run(0, 8, 0);
            run(1, 8, 0);
        end
        // a start held high across a conversion is retaken exactly one rate window after the first take
        sel = 3'h0;
        run(0, 8, 1);
        repeat (25) @(negedge clk);
        wr2 = 1;
        for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 100 && busy === 1'b1; n++) @(negedge clk);
        while (n < 100 && busy !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        wr2 = 0;
        chk(8'(n), 8'h14, "start spacing");
        for (n = 0; n < 100 && busy === 1'b1; n++) @(negedge clk);
        chk(done, 1, "held done");
        dclr = 1;
        @(negedge clk);
        dclr = 0;
        chk(done, 0, "held done clear");
        repeat (25) @(negedge clk);
        sel = 3'h2;
        {en_o, en_s} = 2'b01;
        run(5, 8, 1);
        repeat (25) @(negedge clk);
        en_o = 1;
        run(5, 8, 0);
        repeat (25) @(negedge clk);
        lp = 1;
        sel = 3'h0;
        run(0, 11, 1);
        repeat (25) @(negedge clk);
        sel = 3'h2;
        #1 chk(trk, 1, "lp pin low track");
        run(2, 8, 1);
        repeat (25) @(negedge clk);
        {lp, sel} = 4'h0;
        for (n = 0; n < 3; n++) begin
            // a divider of zero would run the conversion clock above its limit
            div = (n == 0) ? 5'h1f : (5'($random(seed)) | 5'h01);
            ien = 1'($random(seed));
            gap;
            run(0, 8, 1);
            repeat (25) @(negedge clk);
        end
        print_verdict;
    end

    // the whole sequence needs under two thousand cycles
    initial begin
        #2_000_000;
        num_errors++;
        print_verdict;
    end
endmodule : tb_top
